// >>> hw/ssra_pkg.sv
// Purpose: constants, types and register map of the serial register access block
// Assumes: eight-bit registers, seven-bit addresses, one sixteen-bit frame per access
// Notes:   field positions are given as the low bit of each field
package ssra_pkg;

  // --------------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------------
  localparam int NUM_CTRL   = 10;
  localparam int NUM_STAT   = 8;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 7;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [6:0] ADDR_MODE_SUPPLY  = 7'h01;
  localparam logic [6:0] ADDR_HARDWARE     = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG     = 7'h03;
  localparam logic [6:0] ADDR_BUS_ONE      = 7'h04;
  localparam logic [6:0] ADDR_BUS_TWO      = 7'h05;
  localparam logic [6:0] ADDR_WAKE_ONE     = 7'h06;
  localparam logic [6:0] ADDR_WAKE_TWO     = 7'h07;
  localparam logic [6:0] ADDR_WAKE_PULL    = 7'h08;
  localparam logic [6:0] ADDR_CYC_TIMER    = 7'h0C;
  localparam logic [6:0] ADDR_SCRATCH      = 7'h1E;
  localparam logic [6:0] ADDR_SUPPLY_STAT  = 7'h41;
  localparam logic [6:0] ADDR_THERMAL      = 7'h42;
  localparam logic [6:0] ADDR_DEVICE_STAT  = 7'h43;
  localparam logic [6:0] ADDR_BUS_STAT_ONE = 7'h44;
  localparam logic [6:0] ADDR_BUS_STAT_TWO = 7'h45;
  localparam logic [6:0] ADDR_WAKE_SRC_ONE = 7'h46;
  localparam logic [6:0] ADDR_WAKE_SRC_TWO = 7'h47;
  localparam logic [6:0] ADDR_WAKE_LEVEL   = 7'h48;
  localparam logic [6:0] ADDR_REG_STAT     = 7'h4C;
  localparam logic [6:0] ADDR_FAMILY_ID    = 7'h7E;

  // index order of the stored registers; status order is the summary bit order
  localparam logic [NUM_CTRL-1:0][6:0] CTRL_ADDRS = {ADDR_SCRATCH, ADDR_CYC_TIMER,
    ADDR_WAKE_PULL, ADDR_WAKE_TWO, ADDR_WAKE_ONE, ADDR_BUS_TWO, ADDR_BUS_ONE,
    ADDR_WATCHDOG, ADDR_HARDWARE, ADDR_MODE_SUPPLY};
  localparam logic [NUM_STAT-1:0][6:0] STAT_ADDRS = {ADDR_REG_STAT, ADDR_WAKE_SRC_TWO,
    ADDR_WAKE_SRC_ONE, ADDR_BUS_STAT_TWO, ADDR_BUS_STAT_ONE, ADDR_DEVICE_STAT,
    ADDR_THERMAL, ADDR_SUPPLY_STAT};
  localparam logic [3:0] IDX_MODE = 4'h0;
  localparam logic [3:0] IDX_HW   = 4'h1;
  localparam logic [3:0] IDX_BUS1 = 4'h3;
  localparam logic [3:0] IDX_BUS2 = 4'h4;
  localparam logic [3:0] IDX_WAK2 = 4'h6;
  localparam logic [2:0] IDX_DEV  = 3'h2;

  // --------------------------------------------------------------------------
  // reset values and field positions
  // --------------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] STAT_RESET    = 8'h00;
  localparam logic [7:0] MODE_REG_MASK = 8'hDF;
  localparam int MODE_LSB     = 6;
  localparam int REG2_LSB     = 3;
  localparam int CAN_LSB      = 0;
  localparam int LIN1_LSB     = 3;
  localparam int LIN2_LSB     = 0;
  localparam int LIN3_LSB     = 3;
  localparam int FO_ON_BIT    = 5;
  localparam int CMD_FAIL_BIT = 1;
  localparam int WAKE_LVL_BIT = 0;
  localparam int ADDR_READY   = 6;

  // --------------------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] XCVR_ON     = 2'h3;
  localparam logic [1:0] XCVR_WAKE   = 2'h1;

  typedef enum logic [2:0] {
    SSRA_INIT, SSRA_NORMAL, SSRA_STOP, SSRA_SLEEP, SSRA_RESTART, SSRA_FAILSAFE
  } ssra_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic       sel;
    logic [6:0] addr;
  } ssra_frame_t;

  typedef logic [NUM_CTRL-1:0][7:0] ssra_ctrl_t;
  typedef logic [NUM_STAT-1:0][7:0] ssra_stat_t;

endpackage

// >>> hw/ssra_spi_regs.sv
// Purpose: frame decode and register file behind the sixteen-bit serial slave
// Assumes: link clock stops while chip select is high; bits travel lsb first
// Notes:   link logic runs on spi_clk; frame evaluated in clk_sys after select rises
//
// Summary of operation
// RQ1: frame is address, selector bit, data byte
// RQ2: every access touches one whole byte
// RQ3: bits hold until cleared by command
// RQ4: frames ignored in restart, sleep, fail-safe
// RQ5: status contents returned in same frame
// RQ6: control read returns value before write
// RQ7: summary bit set when its register nonzero
// RQ8: summary bit clears when register all zero
// RQ9: summary bits map eight status registers
// RQ10: control range read, or read and write
// RQ11: status range read, or read and clear
// RQ12: wake level live, never cleared
// RQ13: mode bits follow the mode entered
// RQ14: sleep turns transceiver on into wake capable
// RQ15: fail outputs stay on through sleep
// RQ16: regulator config changes only in normal
// RQ17: ten control, eight status registers mapped
// RQ18: family and product code read-only
// RQ19: frame starts low select, acts on rise
// RQ20: sample falling edge, shift rising edge
// RQ21: bad clock count or edges flag error
// RQ22: invalid commands ignored, failure bit set
// RQ23: summary byte first, register byte second
`timescale 1ns/100ps
module ssra_spi_regs
  import ssra_pkg::*;
#(
  parameter logic [3:0] FAMILY_CODE  = 4'h1,  // arbitrary value
  parameter logic [3:0] PRODUCT_CODE = 4'h2   // arbitrary value
) (
  // system
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // serial link
  input  wire logic       spi_clk,
  input  wire logic       chip_select_low,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // device state
  input  ssra_mode_t      sbc_mode,
  input  wire logic       wake_pin,
  input  ssra_stat_t      stat_event,
  input  wire logic       fail_request,
  // control outputs
  output ssra_ctrl_t      ctrl_regs,
  output logic            mode_req_valid,
  output logic [1:0]      mode_req,
  output logic            fail_outputs_on
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    ssra_ctrl_t ctrl;
    ssra_stat_t stat;
    logic       cs_s1, cs_s2, cs_s3;
    logic       clk_s1, clk_s2;
    logic       wk_s1, wk_s2;
    logic       rdy_s1, rdy_s2, rdy_s3;
    logic       link_clr;
    logic       err;
    logic       clk_bad;
    logic [7:0] tx_sif;
    logic [7:0] tx_data;
    ssra_mode_t mode_prev;
    logic       fo_hold;
    logic       req_valid;
    logic [1:0] req;
  } ssra_sys_t;

  typedef struct packed {
    logic [FRAME_BITS-1:0] bits;
    logic [4:0]            cnt;
    logic                  rdy;
  } ssra_rx_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic       sdo;
  } ssra_tx_t;

  ssra_sys_t q, n;
  ssra_rx_t  rx_q, rx_d;
  ssra_tx_t  tx_q, tx_d;

  // --------------------------------------------------------------------------
  // decode functions
  // --------------------------------------------------------------------------
  function automatic logic [4:0] ctrl_lookup(input logic [6:0] a);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < NUM_CTRL; i++) begin
      if (CTRL_ADDRS[i] == a) begin
        r = {1'b1, 4'(i)};  // [RQ10] [RQ17]
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] stat_lookup(input logic [6:0] a);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < NUM_STAT; i++) begin
      if (STAT_ADDRS[i] == a) begin
        r = {1'b1, 3'(i)};  // [RQ11] [RQ17]
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] summary(input ssra_stat_t s);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < NUM_STAT; i++) begin
      r[i] = |s[i];  // [RQ7] [RQ8] [RQ9]
    end
    return r;
  endfunction

  function automatic logic [7:0] read_reg(input ssra_ctrl_t c, input ssra_stat_t s,
                                          input logic wk, input logic [6:0] a);
    logic [4:0] ch;
    logic [3:0] sh;
    logic [7:0] r;
    ch = ctrl_lookup(a);
    sh = stat_lookup(a);
    r  = '0;
    if (ch[4]) begin
      r = c[ch[3:0]];  // [RQ6]
    end else if (sh[3]) begin
      r = s[sh[2:0]];  // [RQ5]
    end else if (a == ADDR_WAKE_LEVEL) begin
      r[WAKE_LVL_BIT] = wk;  // [RQ12]
    end else if (a == ADDR_FAMILY_ID) begin
      r = {FAMILY_CODE, PRODUCT_CODE};  // [RQ18]
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // link receive: sample on falling edge, cleared while select is high
  // --------------------------------------------------------------------------
  always_comb begin
    rx_d = rx_q;
    if (rx_q.cnt < 5'(FRAME_BITS)) begin
      rx_d.bits[rx_q.cnt[3:0]] = sdi;  // [RQ20]
    end
    if (rx_q.cnt <= 5'(FRAME_BITS)) begin
      rx_d.cnt = rx_q.cnt + 5'h01;
    end
    if (rx_q.cnt == 5'(ADDR_READY)) begin
      rx_d.rdy = 1'b1;
    end
  end

  always_ff @(negedge spi_clk or posedge q.link_clr) begin
    if (q.link_clr) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  // --------------------------------------------------------------------------
  // link transmit: shift after rising edge, summary byte then register byte
  // --------------------------------------------------------------------------
  logic [FRAME_BITS-1:0] tx_word;
  assign tx_word = {q.tx_data, q.tx_sif};  // [RQ23]

  always_comb begin
    tx_d = tx_q;
    if (tx_q.cnt < 5'(FRAME_BITS)) begin
      tx_d.sdo = tx_word[tx_q.cnt[3:0]];  // [RQ20]
      tx_d.cnt = tx_q.cnt + 5'h01;
    end else begin
      tx_d.sdo = 1'b0;
    end
  end

  always_ff @(posedge spi_clk or posedge q.link_clr) begin
    if (q.link_clr) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // error of the previous frame shows before the first rising edge
  assign sdo    = (tx_q.cnt == 5'h00) ? q.err : tx_q.sdo;  // [RQ21]
  assign sdo_oe = ~q.cs_s2;  // [RQ19]

  // --------------------------------------------------------------------------
  // frame evaluation helpers
  // --------------------------------------------------------------------------
  ssra_frame_t frame;
  logic        cs_rise, cs_fall, rdy_rise;
  logic        ignore_mode, frame_bad, frame_ok;
  logic [4:0]  c_hit;
  logic [3:0]  s_hit;
  logic [1:0]  req_mode;
  logic        mode_wr, bad_mode;

  assign frame       = ssra_frame_t'(rx_q.bits);  // [RQ1]
  assign cs_rise     = q.cs_s2 & ~q.cs_s3;
  assign cs_fall     = ~q.cs_s2 & q.cs_s3;
  assign rdy_rise    = q.rdy_s2 & ~q.rdy_s3;
  assign ignore_mode = (sbc_mode == SSRA_RESTART) || (sbc_mode == SSRA_SLEEP) ||
                       (sbc_mode == SSRA_FAILSAFE);
  assign frame_bad   = ((rx_q.cnt != 5'h00) && (rx_q.cnt != 5'(FRAME_BITS))) ||
                       q.clk_bad || q.clk_s2;
  assign frame_ok    = cs_rise && (rx_q.cnt == 5'(FRAME_BITS)) && !frame_bad &&
                       !ignore_mode;  // [RQ4] [RQ19]
  assign c_hit       = ctrl_lookup(frame.addr);
  assign s_hit       = stat_lookup(frame.addr);
  assign req_mode    = frame.data[MODE_LSB+1:MODE_LSB];
  assign mode_wr     = frame_ok && frame.sel && c_hit[4] && (c_hit[3:0] == IDX_MODE);
  assign bad_mode    = ((sbc_mode == SSRA_STOP) && (req_mode == MODE_SLEEP)) ||
                       ((sbc_mode == SSRA_INIT) &&
                        ((req_mode == MODE_SLEEP) || (req_mode == MODE_STOP))) ||
                       ((req_mode == MODE_SLEEP) && (q.ctrl[IDX_BUS1] == 8'h00) &&
                        (q.ctrl[IDX_WAK2] == 8'h00));

  // --------------------------------------------------------------------------
  // system side next state
  // --------------------------------------------------------------------------
  always_comb begin
    n           = q;
    n.cs_s1     = chip_select_low;
    n.cs_s2     = q.cs_s1;
    n.cs_s3     = q.cs_s2;
    n.clk_s1    = spi_clk;
    n.clk_s2    = q.clk_s1;
    n.wk_s1     = wake_pin;
    n.wk_s2     = q.wk_s1;
    n.rdy_s1    = rx_q.rdy;
    n.rdy_s2    = q.rdy_s1;
    n.rdy_s3    = q.rdy_s2;
    n.req_valid = 1'b0;
    if (cs_fall) begin
      n.tx_sif   = summary(q.stat);
      n.clk_bad  = q.clk_s2;
      n.link_clr = 1'b0;
    end
    if (rdy_rise) begin
      n.tx_data = read_reg(q.ctrl, q.stat, q.wk_s2, frame.addr);  // [RQ5] [RQ6]
    end
    if (cs_rise) begin
      n.link_clr = 1'b1;
      n.err      = frame_bad;  // [RQ21]
    end
    if (frame_ok && frame.sel) begin
      if (s_hit[3]) begin
        n.stat[s_hit[2:0]] = STAT_RESET;  // [RQ11] [RQ2]
      end
      if (c_hit[4] && (c_hit[3:0] != IDX_MODE)) begin
        n.ctrl[c_hit[3:0]] = frame.data;  // [RQ10] [RQ2]
      end
      if (mode_wr && bad_mode) begin
        n.stat[IDX_DEV][CMD_FAIL_BIT] = 1'b1;  // [RQ22]
      end else if (mode_wr) begin
        n.ctrl[IDX_MODE] = frame.data & MODE_REG_MASK;
        if (sbc_mode != SSRA_NORMAL) begin
          n.ctrl[IDX_MODE][REG2_LSB+1:REG2_LSB] =
            q.ctrl[IDX_MODE][REG2_LSB+1:REG2_LSB];  // [RQ16]
        end
        n.req_valid = 1'b1;
        n.req       = req_mode;
      end
    end
    // events set after the clear so a same-cycle event is kept
    for (int i = 0; i < NUM_STAT; i++) begin
      n.stat[i] = n.stat[i] | stat_event[i];  // [RQ3]
    end
    if (sbc_mode != q.mode_prev) begin
      n.mode_prev = sbc_mode;
      unique case (sbc_mode)
        SSRA_NORMAL: n.ctrl[IDX_MODE][MODE_LSB+1:MODE_LSB] = MODE_NORMAL;  // [RQ13]
        SSRA_STOP:   n.ctrl[IDX_MODE][MODE_LSB+1:MODE_LSB] = MODE_STOP;    // [RQ13]
        SSRA_SLEEP: begin
          n.ctrl[IDX_MODE][MODE_LSB+1:MODE_LSB] = MODE_SLEEP;  // [RQ13]
          if (n.ctrl[IDX_BUS1][CAN_LSB+1:CAN_LSB] == XCVR_ON) begin
            n.ctrl[IDX_BUS1][CAN_LSB+1:CAN_LSB] = XCVR_WAKE;  // [RQ14]
          end
          if (n.ctrl[IDX_BUS1][LIN1_LSB+1:LIN1_LSB] == XCVR_ON) begin
            n.ctrl[IDX_BUS1][LIN1_LSB+1:LIN1_LSB] = XCVR_WAKE;  // [RQ14]
          end
          if (n.ctrl[IDX_BUS2][LIN2_LSB+1:LIN2_LSB] == XCVR_ON) begin
            n.ctrl[IDX_BUS2][LIN2_LSB+1:LIN2_LSB] = XCVR_WAKE;  // [RQ14]
          end
          if (n.ctrl[IDX_BUS2][LIN3_LSB+1:LIN3_LSB] == XCVR_ON) begin
            n.ctrl[IDX_BUS2][LIN3_LSB+1:LIN3_LSB] = XCVR_WAKE;  // [RQ14]
          end
        end
        SSRA_INIT, SSRA_RESTART, SSRA_FAILSAFE: begin
        end
      endcase
    end
    if (sbc_mode == SSRA_SLEEP) begin
      n.fo_hold = q.fo_hold;  // [RQ15]
    end else begin
      n.fo_hold = q.ctrl[IDX_HW][FO_ON_BIT] | fail_request;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q           <= '0;
      q.ctrl      <= {NUM_CTRL{CTRL_RESET}};
      q.stat      <= {NUM_STAT{STAT_RESET}};
      q.cs_s1     <= 1'b1;
      q.cs_s2     <= 1'b1;
      q.cs_s3     <= 1'b1;
      q.link_clr  <= 1'b1;
      q.mode_prev <= SSRA_INIT;
    end else begin
      q <= n;
    end
  end

  assign ctrl_regs       = q.ctrl;
  assign mode_req_valid  = q.req_valid;
  assign mode_req        = q.req;
  assign fail_outputs_on = q.fo_hold;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  chk_err_bad_count: assert property (  // [RQ21]
    @(posedge clk_sys) disable iff (!reset_n)
    cs_rise && (rx_q.cnt != 5'h00) && (rx_q.cnt != 5'(FRAME_BITS)) |=> q.err)
    else $error("bad clock count not flagged");

  chk_ignore_frames: assert property (  // [RQ4]
    @(posedge clk_sys) disable iff (!reset_n)
    cs_rise && ignore_mode && (sbc_mode == q.mode_prev) && (sbc_mode == $past(sbc_mode))
    |=> $stable(q.ctrl))
    else $error("frame acted on in ignored mode");

  chk_hw_write: assert property (  // [RQ10]
    @(posedge clk_sys) disable iff (!reset_n)
    frame_ok && frame.sel && (frame.addr == ADDR_HARDWARE)
    |=> q.ctrl[IDX_HW] == $past(frame.data))
    else $error("control write lost");

  chk_read_clear: assert property (  // [RQ11]
    @(posedge clk_sys) disable iff (!reset_n)
    frame_ok && frame.sel && (frame.addr == ADDR_THERMAL)
    |=> q.stat[1] == $past(stat_event[1]))
    else $error("status not cleared by read-clear");

  chk_summary_set: assert property (  // [RQ7]
    @(posedge clk_sys) disable iff (!reset_n)
    cs_fall && (q.stat[0] != 8'h00) |=> q.tx_sif[0] ##1 $stable(q.tx_sif))
    else $error("summary bit missing");

  chk_wake_level: assert property (  // [RQ12]
    @(posedge clk_sys) disable iff (!reset_n)
    rdy_rise && (frame.addr == ADDR_WAKE_LEVEL) |=> q.tx_data == {7'h00, $past(q.wk_s2)})
    else $error("wake level read wrong");

  chk_sleep_rewrite: assert property (  // [RQ14]
    @(posedge clk_sys) disable iff (!reset_n)
    (sbc_mode == SSRA_SLEEP) && (q.mode_prev != SSRA_SLEEP) && !frame_ok &&
    (q.ctrl[IDX_BUS1][CAN_LSB+1:CAN_LSB] == XCVR_ON)
    |=> q.ctrl[IDX_BUS1][CAN_LSB+1:CAN_LSB] == XCVR_WAKE)
    else $error("transceiver left on at sleep");

  chk_reg2_normal: assert property (  // [RQ16]
    @(posedge clk_sys) disable iff (!reset_n)
    mode_wr && !bad_mode && (sbc_mode != SSRA_NORMAL)
    |=> $stable(q.ctrl[IDX_MODE][REG2_LSB+1:REG2_LSB]))
    else $error("regulator config changed outside normal");

  chk_fail_hold: assert property (  // [RQ15]
    @(posedge clk_sys) disable iff (!reset_n)
    fail_outputs_on && (sbc_mode == SSRA_SLEEP) ##1 (sbc_mode == SSRA_SLEEP)
    |-> fail_outputs_on)
    else $error("fail outputs dropped in sleep");

  chk_cmd_fail: assert property (  // [RQ22]
    @(posedge clk_sys) disable iff (!reset_n)
    mode_wr && bad_mode |=> q.stat[IDX_DEV][CMD_FAIL_BIT] && !mode_req_valid)
    else $error("invalid command not flagged");

endmodule

// >>> verif/ssra_spi_master.sv
// Purpose: serial bus master model that sends frames to the register block
// Assumes: link clock idles low, 30 ns period, bits go lsb first
// Notes:   sdo has no pull, so a released line reads back the inverted last value
`timescale 1ns/100ps
module ssra_spi_master (
  // serial link
  output logic      spi_clk,
  output logic      chip_select_low,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic last_q;
  logic line;

  assign line = sdo_oe ? sdo : ~last_q;

  initial begin
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    sdi = 1'b0;
    last_q = 1'b0;
  end

  // address, selector and data travel as one word
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx,
                      output logic err);
    rx = 16'h0000;
    #45;
    chip_select_low = 1'b0; // frame opens with select low
    #45;
    err = line;
    last_q = line;
    for (int i = 0; i < n; i++) begin
      spi_clk = 1'b1;
      sdi = tx[i]; // changed after the rising edge
      #15;
      spi_clk = 1'b0;
      rx[i] = line; // sampled on the falling edge
      last_q = line;
      #15;
    end
    chip_select_low = 1'b1; // select rise ends the frame
    sdi = ~sdi;
  endtask
endmodule

// >>> verif/sbc_spi_register_access_tb.sv
// Purpose: self-checking bench for the serial register access block
// Assumes: system clock 4 ns, link clock 30 ns from the master model
// Notes:   a byte-wide model in arrays predicts each sixteen-bit response outside sleep, restart and fail-safe, and every register
`timescale 1ns/100ps
module sbc_spi_register_access_tb import ssra_pkg::*; ();
  logic       clk_sys;
  logic       reset_n;
  logic       spi_clk;
  logic       chip_select_low;
  logic       sdi;
  logic       sdo;
  logic       sdo_oe;
  ssra_mode_t sbc_mode;
  logic       wake_pin;
  ssra_stat_t stat_event;
  logic       fail_request;
  ssra_ctrl_t ctrl_regs;
  logic       mode_req_valid;
  logic [1:0] mode_req;
  logic       fail_outputs_on;
  logic [7:0] m_ctrl [NUM_CTRL];
  logic [7:0] m_stat [NUM_STAT];
  logic       got;
  logic [1:0] got_mode;
  logic       last_err;
  int         n_mismatch;
  int         checked;

  ssra_spi_regs #(.FAMILY_CODE(4'h1), .PRODUCT_CODE(4'h2)) ssra_spi_regs_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .spi_clk(spi_clk),
    .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .sbc_mode(sbc_mode), .wake_pin(wake_pin), .stat_event(stat_event),
    .fail_request(fail_request), .ctrl_regs(ctrl_regs), .mode_req_valid(mode_req_valid),
    .mode_req(mode_req), .fail_outputs_on(fail_outputs_on));

  ssra_spi_master ssra_spi_master_inst (
    .spi_clk(spi_clk), .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));

  always #2 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------------------
  // model and checking helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    exp_rd = 8'h00;
    for (int i = 0; i < NUM_CTRL; i++) if (CTRL_ADDRS[i] == a) exp_rd = m_ctrl[i];
    for (int i = 0; i < NUM_STAT; i++) if (STAT_ADDRS[i] == a) exp_rd = m_stat[i];
    if (a == ADDR_WAKE_LEVEL) exp_rd = {7'h00, wake_pin};
    if (a == ADDR_FAMILY_ID) exp_rd = 8'h12;
  endfunction

  function automatic logic [7:0] exp_sum();
    for (int i = 0; i < NUM_STAT; i++) exp_sum[i] = |m_stat[i];
  endfunction

  function automatic logic [7:0] wake_cap(input logic [7:0] b);
    wake_cap = b;
    if (b[CAN_LSB+:2] == XCVR_ON) wake_cap[CAN_LSB+:2] = XCVR_WAKE;
    if (b[LIN1_LSB+:2] == XCVR_ON) wake_cap[LIN1_LSB+:2] = XCVR_WAKE;
  endfunction

  task automatic frame(input logic [6:0] a, input logic s, input logic [7:0] d, input int n);
    logic [15:0] rx;
    logic        err;
    logic        live;
    live = !(sbc_mode inside {SSRA_SLEEP, SSRA_RESTART, SSRA_FAILSAFE});
    ssra_spi_master_inst.xfer({d, s, a}, n, rx, err);
    last_err = err;
    if (live && n == 16) chk(rx, {exp_rd(a), exp_sum()});
    got = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      if (mode_req_valid === 1'b1) begin
        got = 1'b1;
        got_mode = mode_req;
      end
    end
    chk(16'(sdo_oe), 16'h0000);
    if (live && n == 16 && s) begin
      for (int i = 1; i < NUM_CTRL; i++) if (CTRL_ADDRS[i] == a) m_ctrl[i] = d;
      for (int i = 0; i < NUM_STAT; i++) if (STAT_ADDRS[i] == a) m_stat[i] = 8'h00;
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    void'($urandom(16));
    clk_sys = 1'b0;
    reset_n = 1'b0;
    sbc_mode = SSRA_NORMAL;
    wake_pin = 1'b0;
    stat_event = '0;
    fail_request = 1'b0;
    n_mismatch = 0;
    checked = 0;
    foreach (m_ctrl[i]) m_ctrl[i] = CTRL_RESET;
    foreach (m_stat[i]) m_stat[i] = STAT_RESET;
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    for (int i = 0; i < NUM_CTRL; i++) frame(CTRL_ADDRS[i], 1'b0, 8'h00, 16);
    for (int i = 0; i < NUM_STAT; i++) frame(STAT_ADDRS[i], 1'b0, 8'h00, 16);
    frame(ADDR_FAMILY_ID, 1'b1, 8'hFF, 16);
    frame(ADDR_FAMILY_ID, 1'b0, 8'h00, 16);
    frame(7'h10, 1'b1, 8'h5A, 16);
    frame(7'h10, 1'b0, 8'h00, 16);
    done("reset_map");
    for (int i = 1; i < NUM_CTRL; i++) begin
      v = 8'($urandom);
      frame(CTRL_ADDRS[i], 1'b1, v, 16);
      frame(CTRL_ADDRS[i], 1'b0, 8'h00, 16);
      chk(16'(ctrl_regs[i]), 16'(m_ctrl[i]));
    end
    chk(16'(fail_outputs_on), 16'(m_ctrl[IDX_HW][FO_ON_BIT]));
    done("control_rw");
    frame(ADDR_SCRATCH, 1'b1, 8'hA5, 9);
    frame(ADDR_SCRATCH, 1'b0, 8'h00, 16);
    chk(16'(last_err), 16'h0001);
    frame(ADDR_SCRATCH, 1'b0, 8'h00, 0);
    frame(ADDR_SCRATCH, 1'b0, 8'h00, 16);
    chk(16'(last_err), 16'h0000);
    done("clock_count");
    for (int j = 0; j < NUM_STAT; j++) begin
      v = 8'($urandom_range(1, 255));
      @(negedge clk_sys);
      stat_event[j] = v;
      @(negedge clk_sys);
      stat_event = '0;
      m_stat[j] |= v;
      frame(STAT_ADDRS[j], 1'b0, 8'h00, 16);
      frame(STAT_ADDRS[j], 1'b1, 8'h00, 16);
      frame(STAT_ADDRS[j], 1'b0, 8'h00, 16);
    end
    wake_pin = 1'b1;
    frame(ADDR_WAKE_LEVEL, 1'b1, 8'h00, 16);
    frame(ADDR_WAKE_LEVEL, 1'b0, 8'h00, 16);
    done("status");
    frame(ADDR_MODE_SUPPLY, 1'b1, {MODE_STOP, 6'h00}, 16);
    chk(16'({got, got_mode}), 16'({1'b1, MODE_STOP}));
    m_ctrl[IDX_MODE] = {MODE_STOP, 6'h00};
    sbc_mode = SSRA_STOP;
    frame(ADDR_MODE_SUPPLY, 1'b1, {MODE_STOP, 6'h18}, 16);
    chk(16'(ctrl_regs[IDX_MODE]), 16'(m_ctrl[IDX_MODE]));
    frame(ADDR_MODE_SUPPLY, 1'b1, {MODE_SLEEP, 6'h00}, 16);
    chk(16'(got), 16'h0000);
    m_stat[IDX_DEV][CMD_FAIL_BIT] = 1'b1;
    frame(ADDR_DEVICE_STAT, 1'b0, 8'h00, 16);
    frame(ADDR_MODE_SUPPLY, 1'b0, 8'h00, 16);
    sbc_mode = SSRA_NORMAL;
    m_ctrl[IDX_MODE] = 8'h00;
    frame(ADDR_MODE_SUPPLY, 1'b0, 8'h00, 16);
    done("mode_write");
    frame(ADDR_BUS_ONE, 1'b1, 8'h1B, 16);
    fail_request = 1'b1;
    frame(ADDR_HARDWARE, 1'b1, 8'h00, 16);
    sbc_mode = SSRA_SLEEP;
    fail_request = 1'b0;
    repeat (4) @(negedge clk_sys);
    m_ctrl[IDX_BUS1] = wake_cap(m_ctrl[IDX_BUS1]);
    m_ctrl[IDX_BUS2] = wake_cap(m_ctrl[IDX_BUS2]);
    chk(16'(ctrl_regs[IDX_BUS1]), 16'(m_ctrl[IDX_BUS1]));
    chk(16'(ctrl_regs[IDX_BUS2]), 16'(m_ctrl[IDX_BUS2]));
    chk(16'(ctrl_regs[IDX_MODE][7:6]), 16'(MODE_SLEEP));
    chk(16'(fail_outputs_on), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      sbc_mode = (k == 0) ? SSRA_SLEEP : ((k == 1) ? SSRA_RESTART : SSRA_FAILSAFE);
      frame(ADDR_HARDWARE, 1'b1, 8'hFF, 16);
      chk(16'(ctrl_regs[IDX_HW]), 16'(m_ctrl[IDX_HW]));
    end
    chk(16'(fail_outputs_on), 16'h0000);
    sbc_mode = SSRA_NORMAL;
    fail_request = 1'b1;
    frame(ADDR_MODE_SUPPLY, 1'b0, 8'h00, 16);
    chk(16'(fail_outputs_on), 16'h0001);
    done("low_power");
    tally_and_finish();
  end
endmodule
